// ---- shared/jps_pkg.sv ----
// package for the test-access pin sharing control block
// assumes a single 125 MHz core clock; test pins are sampled, not used as clocks
package jps_pkg;
  // core clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // test clock cycles of tms high that bring the tap to test-logic-reset
  localparam int unsigned TMS_HIGH_RESET_CYCLES = 5;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic FUSE_BLOWN = 1'b1;

  // the sixteen tap controller states
  typedef enum logic [3:0] {
    JPS_TLR, JPS_RTI, JPS_SEL_DR, JPS_CAP_DR, JPS_SHF_DR, JPS_EX1_DR, JPS_PAU_DR,
    JPS_EX2_DR, JPS_UPD_DR, JPS_SEL_IR, JPS_CAP_IR, JPS_SHF_IR, JPS_EX1_IR,
    JPS_PAU_IR, JPS_EX2_IR, JPS_UPD_IR
  } jps_tap_t;
endpackage : jps_pkg

// ---- rtl/jps_sync.sv ----
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk_i
module jps_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
      $error("jps_sync width must be at least one");
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : jps_sync

// ---- rtl/jps_ctrl.sv ----
// test-access pin sharing control: tap state tracking and pin ownership
// assumes tck is slow against clk_i (several core cycles per half period)
// and that the fuse level is static while out of reset
module jps_ctrl
  import jps_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration
  input wire logic fuse_blown_i,
  // test pins from outside
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic trst_n_i,
  input wire logic tdi_i,
  // tap data path
  input wire logic tdo_data_i,
  input wire logic tdo_en_i,
  // user logic side of the shared pins
  input wire logic user_tdo_pin_i,
  input wire logic user_tdo_oe_i,
  // status and pin control
  output logic test_owns_pins_o,
  output logic dedicated_o,
  output logic tap_active_o,
  output logic tck_rise_o,
  output logic tdi_o,
  output jps_pkg::jps_tap_t tap_state_o,
  output logic tdo_pin_o,
  output logic tdo_pin_oe_o
);
  // How it works
  // - fuse blown: tck, tdi, tdo are test pins, user i/o only in the first cycle after reset release
  // - fuse intact: tck, tdi, tdo serve user i/o while test is idle
  // - mode comes from the fuse alone; intact fuse means flexible
  // - flexible mode: tms low hands tck, tdi, tdo to the test port
  // - trst low disables all test function in flexible mode; in dedicated mode it holds the tap in reset and tdo off, pins stay owned
  // - shared pins stay in test use until tap reaches test-logic-reset
  // - flexible mode: at test-logic-reset the shared pins return to user i/o
  // - five tck cycles of tms high bring the tap to test-logic-reset
  // - dedicated mode: tms follows the standard tap walk only

  logic tck_s, tms_s, trst_n_s, tdi_s;
  logic tck_prev_q;
  logic fuse_q;
  logic owns_q, owns_d;
  jps_tap_t tap_q, tap_d;
  logic [2:0] hi_cnt_q;

  jps_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({tck_i, tms_i, trst_n_i, tdi_i}),
    .sync_o({tck_s, tms_s, trst_n_s, tdi_s})
  );

  function automatic jps_tap_t tap_next(input jps_tap_t s, input logic tms);
    jps_tap_t n;
    n = s;
    case (s)
      JPS_TLR: n = tms ? JPS_TLR : JPS_RTI;
      JPS_RTI: n = tms ? JPS_SEL_DR : JPS_RTI;
      JPS_SEL_DR: n = tms ? JPS_SEL_IR : JPS_CAP_DR;
      JPS_CAP_DR: n = tms ? JPS_EX1_DR : JPS_SHF_DR;
      JPS_SHF_DR: n = tms ? JPS_EX1_DR : JPS_SHF_DR;
      JPS_EX1_DR: n = tms ? JPS_UPD_DR : JPS_PAU_DR;
      JPS_PAU_DR: n = tms ? JPS_EX2_DR : JPS_PAU_DR;
      JPS_EX2_DR: n = tms ? JPS_UPD_DR : JPS_SHF_DR;
      JPS_UPD_DR: n = tms ? JPS_SEL_DR : JPS_RTI;
      JPS_SEL_IR: n = tms ? JPS_TLR : JPS_CAP_IR;
      JPS_CAP_IR: n = tms ? JPS_EX1_IR : JPS_SHF_IR;
      JPS_SHF_IR: n = tms ? JPS_EX1_IR : JPS_SHF_IR;
      JPS_EX1_IR: n = tms ? JPS_UPD_IR : JPS_PAU_IR;
      JPS_PAU_IR: n = tms ? JPS_EX2_IR : JPS_PAU_IR;
      JPS_EX2_IR: n = tms ? JPS_UPD_IR : JPS_SHF_IR;
      JPS_UPD_IR: n = tms ? JPS_SEL_DR : JPS_RTI;
      default: n = JPS_TLR;
    endcase
    return n;
  endfunction : tap_next

  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;
  // the tap only walks with trst high; low trst pins it in reset
  wire test_enabled = trst_n_s;
  wire dedicated = (fuse_q == FUSE_BLOWN);
  // in flexible mode a low tms claims the pins right away
  wire claim = ~dedicated & test_enabled & ~tms_s;
  wire tap_step = test_enabled & tck_rise & (dedicated | owns_q | claim);

  always_comb
  begin
    tap_d = tap_q;
    if (!test_enabled)
      tap_d = JPS_TLR;
    else if (tap_step)
      tap_d = tap_next(tap_q, tms_s);
  end

  always_comb
  begin
    owns_d = owns_q;
    if (dedicated)
      owns_d = 1'b1;
    else if (!test_enabled)
      owns_d = 1'b0;
    else if (claim)
      owns_d = 1'b1;
    else if (owns_q && tap_step && tap_d == JPS_TLR)
      owns_d = 1'b0;
  end // otherwise ownership holds

  // fuse is sampled after reset release; it is static, so one flop suffices
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fuse_q <= 1'b0;
    else
      fuse_q <= fuse_blown_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tck_prev_q <= 1'b0;
      tap_q <= JPS_TLR;
      owns_q <= 1'b0;
    end
    else
    begin
      tck_prev_q <= tck_s;
      tap_q <= tap_d;
      owns_q <= owns_d;
    end
  end

  // run length of tms-high rising edges, for the checks below
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hi_cnt_q <= '0;
    else if (tap_step)
      hi_cnt_q <= !tms_s ? 3'h0 : (hi_cnt_q == 3'h7 ? hi_cnt_q : hi_cnt_q + 3'h1);
  end

  // tdo is driven on the falling tck edge as the standard asks
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      test_owns_pins_o <= 1'b0;
      dedicated_o <= 1'b0;
      tap_active_o <= 1'b0;
      tck_rise_o <= 1'b0;
      tdi_o <= 1'b0;
      tap_state_o <= JPS_TLR;
      tdo_pin_o <= 1'b0;
      tdo_pin_oe_o <= 1'b0;
    end
    else
    begin
      test_owns_pins_o <= owns_d;
      dedicated_o <= dedicated;
      tap_active_o <= test_enabled & (tap_d != JPS_TLR);
      tck_rise_o <= tap_step;
      tdi_o <= owns_d ? tdi_s : 1'b0;
      tap_state_o <= tap_d;
      if (!owns_d)
      begin
        tdo_pin_o <= user_tdo_pin_i;
        tdo_pin_oe_o <= user_tdo_oe_i;
      end
      else if (!test_enabled)
        tdo_pin_oe_o <= 1'b0;
      else if (tck_fall)
      begin
        tdo_pin_o <= tdo_data_i;
        tdo_pin_oe_o <= tdo_en_i & test_enabled;
      end
    end
  end

  chk_trst_holds_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !trst_n_s |=> tap_q == JPS_TLR)
    else $error("tap left reset while trst low");
  chk_dedicated_owns: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dedicated |=> owns_q)
    else $error("dedicated mode released the pins");
  chk_tms_low_claims: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!dedicated && trst_n_s && !tms_s) |=> owns_q && test_owns_pins_o)
    else $error("tms low did not claim the pins");
  chk_hold_until_tlr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (owns_q && !owns_d && trst_n_s) |-> tap_d == JPS_TLR)
    else $error("pins released outside test-logic-reset");
  chk_release_at_tlr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!dedicated && tap_q == JPS_TLR && tms_s && !claim && $past(tap_q) != JPS_TLR)
      |-> !owns_q)
    else $error("pins kept after test-logic-reset");
  chk_five_high_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tap_step && tms_s && hi_cnt_q == 3'(TMS_HIGH_RESET_CYCLES - 1)) |=> tap_q == JPS_TLR)
    else $error("five tms-high edges did not reach reset");
  chk_flex_user_pins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!dedicated && !owns_q && tms_s) |=> !owns_q)
    else $error("pins taken without tms low");
  chk_tap_walk: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dedicated && trst_n_s && tck_rise) |=> tap_q == tap_next($past(tap_q), $past(tms_s)))
    else $error("tap walk differs from the standard");

  cov_claim: cover property (@(posedge clk_i) disable iff (!resetn_i) !owns_q ##1 owns_q);
  cov_release: cover property (@(posedge clk_i) disable iff (!resetn_i) owns_q ##1 !owns_q);
  cov_shift_dr: cover property (@(posedge clk_i) disable iff (!resetn_i) tap_q == JPS_SHF_DR);
  cov_trst: cover property (@(posedge clk_i) disable iff (!resetn_i) owns_q && !trst_n_s);
endmodule : jps_ctrl

// ---- bench/jps_host.sv ----
// boundary-scan controller model driving the test pins of the sharing block
// assumes the bench calls its tasks; tck stands low between frames
module jps_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic trst_n = 1'b1;
  logic tdi = 1'b0;
  // one tck cycle, 125 ns, tms and tdi set up half a period before the rise
  task step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    #62.5 tck = 1'b0;
  endtask : step
  // tms has a pull-up; tdi is undriven, so it shows the inverse of its last value
  task idle();
    tms = 1'b1;
    tdi = ~tdi;
  endtask : idle
  task set_trst(input logic lvl);
    trst_n = lvl;
  endtask : set_trst
endmodule : jps_host

// ---- bench/testbench.sv ----
// self-checking bench for the pin sharing control block
// assumes jps_pkg compiled first; the host model drives the test pins
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import jps_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic fuse_blown_i = 1'b0;
  logic [3:0] rnd_q = 4'h0;
  logic owns, ded, act, rise, tdi_o, tdo_o, tdo_oe;
  jps_tap_t st;
  logic [31:0] xs = 32'h0000_7654;
  logic [5:0] notes[$];
  event note_ev;
  int errors = 0;
  int cmp_count = 0;
  always #4 clk_i = ~clk_i;
  jps_host host();
  jps_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .fuse_blown_i(fuse_blown_i),
    .tck_i(host.tck), .tms_i(host.tms), .trst_n_i(host.trst_n), .tdi_i(host.tdi),
    .tdo_data_i(rnd_q[0]), .tdo_en_i(rnd_q[1]), .user_tdo_pin_i(rnd_q[2]),
    .user_tdo_oe_i(rnd_q[3]), .test_owns_pins_o(owns), .dedicated_o(ded),
    .tap_active_o(act), .tck_rise_o(rise), .tdi_o(tdi_o), .tap_state_o(st),
    .tdo_pin_o(tdo_o), .tdo_pin_oe_o(tdo_oe));
  // random data reaches the tdo path each falling edge
  always @(negedge clk_i)
  begin
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    rnd_q <= xs[3:0];
  end
  task test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task check_pins(input logic [5:0] n);
    cmp_count++;
    if (ded !== n[5] || owns !== n[4] || st !== jps_tap_t'(n[3:0])
        || act !== (n[3:0] != 4'h0) || (!n[4] && tdi_o !== 1'b0))
    begin
      errors++;
      $display("ERROR %0t pins ded %b owns %b state %0d", $time, ded, owns, st);
    end
  endtask : check_pins
  always @(note_ev) check_pins(notes.pop_front());
  // compare on the falling edge, where registered outputs are settled
  task expect_pins(input logic d, input logic o, input jps_tap_t s);
    @(negedge clk_i);
    notes.push_back({d, o, 4'(s)});
    -> note_ev;
    #1;
  endtask : expect_pins
  // user side of tdo: the value sampled at the last rising edge must show while not owned
  task check_tdo(input logic v, input logic e);
    cmp_count++;
    if (tdo_o !== v || tdo_oe !== e)
    begin
      errors++;
      $display("ERROR %0t tdo %b oe %b expected %b %b", $time, tdo_o, tdo_oe, v, e);
    end
  endtask : check_tdo
  always @(negedge clk_i)
  begin
    if (resetn_i && owns === 1'b0)
      check_tdo(rnd_q[2], rnd_q[3]);
  end
  task do_reset(input logic f);
    resetn_i = 1'b0;
    fuse_blown_i = f;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : do_reset
  // climb to shift-dr, then walk five tms-high steps back to reset
  task walk(input logic f);
    host.step(1'b0, 1'b1);
    expect_pins(f, 1'b1, JPS_RTI);
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b1);
    host.step(1'b0, 1'b0);
    expect_pins(f, 1'b1, JPS_SHF_DR);
    repeat (4) host.step(1'b1, 1'b1);
    expect_pins(f, 1'b1, JPS_SEL_IR);
    host.step(1'b1, 1'b0);
    host.idle();
    repeat (4) @(negedge clk_i);
    expect_pins(f, f, JPS_TLR);
  endtask : walk
  task trst_pulse(input logic f);
    host.step(1'b0, 1'b1);
    host.set_trst(1'b0);
    repeat (10) @(negedge clk_i);
    expect_pins(f, f, JPS_TLR);
    host.step(1'b0, 1'b0);
    expect_pins(f, f, JPS_TLR);
    host.set_trst(1'b1);
    host.idle();
    repeat (10) @(negedge clk_i);
  endtask : trst_pulse
  initial
  begin
    #500000;
    errors++;
    test_done();
  end
  initial
  begin
    do_reset(1'b0);
    expect_pins(1'b0, 1'b0, JPS_TLR);
    repeat (3) host.step(1'b1, 1'b1);
    expect_pins(1'b0, 1'b0, JPS_TLR);
    walk(1'b0);
    trst_pulse(1'b0);
    $display("test flexible done");
    do_reset(1'b1);
    expect_pins(1'b1, 1'b1, JPS_TLR);
    repeat (3) host.step(1'b1, 1'b0);
    expect_pins(1'b1, 1'b1, JPS_TLR);
    walk(1'b1);
    trst_pulse(1'b1);
    $display("test dedicated done");
    test_done();
  end
endmodule : testbench
